// *** rtl/tcc_pkg.sv ***
/*
  Constants for the 16-bit timer/event counter with capture and compare:
  register indices and byte addresses, field positions, reset values and
  prescaler taps. Assumes a 32-bit AXI4-Lite bus where each indexed register takes
  one aligned word at four times its index.
*/
package tcc_pkg;

  // Register indices as printed; the bus address is four times the index.
  localparam logic [15:0] IDX_DBUF_CTRL   = 16'hffcd;
  localparam logic [15:0] IDX_RUN_CTRL    = 16'hffce;
  localparam logic [15:0] IDX_CAP1_LO     = 16'hffcf;
  localparam logic [15:0] IDX_CAP1_HI     = 16'hffd0;
  localparam logic [15:0] IDX_CAP2_LO     = 16'hffd1;
  localparam logic [15:0] IDX_CAP2_HI     = 16'hffd2;
  localparam logic [15:0] IDX_MODE        = 16'hffd3;
  localparam logic [15:0] IDX_FF_CTRL     = 16'hffd4;

  localparam logic [31:0] ADDR_DBUF_CTRL  = {14'h0000, IDX_DBUF_CTRL, 2'b00};
  localparam logic [31:0] ADDR_RUN_CTRL   = {14'h0000, IDX_RUN_CTRL, 2'b00};
  localparam logic [31:0] ADDR_CAP1_LO    = {14'h0000, IDX_CAP1_LO, 2'b00};
  localparam logic [31:0] ADDR_CAP1_HI    = {14'h0000, IDX_CAP1_HI, 2'b00};
  localparam logic [31:0] ADDR_CAP2_LO    = {14'h0000, IDX_CAP2_LO, 2'b00};
  localparam logic [31:0] ADDR_CAP2_HI    = {14'h0000, IDX_CAP2_HI, 2'b00};
  localparam logic [31:0] ADDR_MODE       = {14'h0000, IDX_MODE, 2'b00};
  localparam logic [31:0] ADDR_FF_CTRL    = {14'h0000, IDX_FF_CTRL, 2'b00};
  localparam logic [31:0] ADDR_IRQ_STATUS = 32'h0004_0000;
  localparam logic [31:0] ADDR_IRQ_MASK   = 32'h0004_0004;

  // Mode register fields.
  localparam int MODE_TOG_CAP2_B  = 7;
  localparam int MODE_TOG_MATCH_B = 6;
  localparam int MODE_SW_CAPTURE  = 5;
  localparam int MODE_CAPT_LO     = 3;
  localparam int MODE_CLEAR_EN    = 2;
  localparam int MODE_CLK_LO      = 0;
  localparam logic [7:0] MODE_RESET = 8'h20;

  // Output flip-flop control fields.
  localparam int FFC_B_LO        = 6;
  localparam int FFC_A_CAP2      = 5;
  localparam int FFC_A_CAP1      = 4;
  localparam int FFC_A_MATCH_B   = 3;
  localparam int FFC_A_MATCH_A   = 2;
  localparam int FFC_A_LO        = 0;
  localparam logic [7:0] FFC_RESET = 8'hc3;

  // Other control fields.
  localparam int DBUF_EN_BIT     = 2;
  localparam int RUN_COUNTER_BIT = 4;
  localparam int RUN_PRESCALE_BIT = 5;
  localparam logic [7:0] DBUF_RESET = 8'h00;
  localparam logic [7:0] RUN_RESET  = 8'h00;

  // Interrupt status bit positions.
  localparam int IRQ_MATCH_A = 0;
  localparam int IRQ_MATCH_B = 1;
  localparam int IRQ_CAP1    = 2;
  localparam int IRQ_CAP2    = 3;

  // Prescaler taps in system clocks.
  localparam int TAP_FAST  = 8;
  localparam int TAP_MID   = 32;
  localparam int TAP_SLOW  = 128;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    TCC_CLK_PIN  = 2'b00,
    TCC_CLK_FAST = 2'b01,
    TCC_CLK_MID  = 2'b10,
    TCC_CLK_SLOW = 2'b11
  } tcc_clk_src_t;

  typedef enum logic [1:0] {
    TCC_CAP_OFF      = 2'b00,
    TCC_CAP_TWO_PINS = 2'b01,
    TCC_CAP_PIN_BOTH = 2'b10,
    TCC_CAP_TIMER_FF = 2'b11
  } tcc_cap_mode_t;

  typedef enum logic [1:0] {
    TCC_FF_INVERT = 2'b00,
    TCC_FF_SET    = 2'b01,
    TCC_FF_CLEAR  = 2'b10,
    TCC_FF_KEEP   = 2'b11
  } tcc_ff_cmd_t;

endpackage : tcc_pkg

// *** rtl/tcc_timer.sv ***
/*
  16-bit up-counting timer/event counter with two capture registers, two
  compare registers, two output flip-flops and an AXI4-Lite register slave.
  Assumes event pins and the other timer's flip-flop are synchronous to aclk.
*/
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/100ps

// Behaviour
// - Toggle enables invert second flip-flop on events.
// - Writing 0 to software capture bit captures.
// - Capture timing field selects capture edge sources.
// - Clear enable clears counter on compare B match.
// - Clock source field selects pin or prescaler.
// - Flip-flop control writes invert, set, clear, keep.
// - Match on compare B inverts output flip-flop.
module tcc_timer (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [31:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [31:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        first_event_pin,
  input  wire logic        second_event_pin,
  input  wire logic        first_timer_flipflop,
  output logic             output_flipflop_a,
  output logic             second_output_flipflop,
  output logic             irq
);
  import tcc_pkg::*;

  logic        aw_hold_reg;
  logic [31:0] aw_addr_reg;
  logic        w_hold_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic        rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;
  logic        do_write;
  logic        wr_byte;
  logic        ar_fire;
  logic [31:0] rd_mux;
  logic        rd_hit;
  logic        wr_hit;

  logic [7:0]  dbuf_reg;
  logic [7:0]  run_reg;
  logic [7:0]  mode_reg;
  logic [5:0]  ffc_en_reg;
  logic [15:0] cmp_a_buf_reg;
  logic [15:0] cmp_b_buf_reg;
  logic [15:0] cmp_a_reg;
  logic [15:0] cmp_b_reg;
  logic [15:0] count_reg;
  logic [15:0] cap1_reg;
  logic [15:0] cap2_reg;
  logic [6:0]  pre_reg;
  logic        pin1_prev_reg;
  logic        pin2_prev_reg;
  logic        first_timer_flipflop_prev_reg;
  logic        ff_a_reg;
  logic        ff_b_reg;
  logic [3:0]  irq_status_reg;
  logic [3:0]  irq_mask_reg;

  logic        tick;
  logic        match_a;
  logic        match_b;
  logic        cap1_hw;
  logic        cap2_hw;
  logic        sw_capture;
  logic [3:0]  events;
  logic        status_rd_clear;
  logic        run;
  logic        wr_ffc;
  logic        ffb_toggle;
  logic        ffa_toggle;

  // Bus slave: address and data are latched separately so either may come first.
  assign awready  = !aw_hold_reg;
  assign wready   = !w_hold_reg;
  assign bvalid   = bvalid_reg;
  assign bresp    = bresp_reg;
  assign arready  = !rvalid_reg;
  assign rvalid   = rvalid_reg;
  assign rdata    = rdata_reg;
  assign rresp    = rresp_reg;
  assign do_write = aw_hold_reg && w_hold_reg && !bvalid_reg;
  assign wr_byte  = do_write && w_strb_reg[0];
  assign ar_fire  = arvalid && !rvalid_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg <= 1'b0;
      aw_addr_reg <= 32'h0000_0000;
    end else if (awvalid && !aw_hold_reg) begin
      aw_hold_reg <= 1'b1;
      aw_addr_reg <= awaddr;
    end else if (do_write) begin
      aw_hold_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
    end else if (wvalid && !w_hold_reg) begin
      w_hold_reg <= 1'b1;
      w_data_reg <= wdata;
      w_strb_reg <= wstrb;
    end else if (do_write) begin
      w_hold_reg <= 1'b0;
    end
  end

  always_comb begin
    wr_hit = 1'b1;
    if (aw_addr_reg == ADDR_DBUF_CTRL) begin
      wr_hit = 1'b1;
    end else if (aw_addr_reg == ADDR_RUN_CTRL) begin
      wr_hit = 1'b1;
    end else if (aw_addr_reg == ADDR_CAP1_LO || aw_addr_reg == ADDR_CAP1_HI) begin
      wr_hit = 1'b1;
    end else if (aw_addr_reg == ADDR_CAP2_LO || aw_addr_reg == ADDR_CAP2_HI) begin
      wr_hit = 1'b1;
    end else if (aw_addr_reg == ADDR_MODE || aw_addr_reg == ADDR_FF_CTRL) begin
      wr_hit = 1'b1;
    end else if (aw_addr_reg == ADDR_IRQ_MASK) begin
      wr_hit = 1'b1;
    end else begin
      wr_hit = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // Compare registers share offsets with the read-only capture registers.
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    if (araddr == ADDR_DBUF_CTRL) begin
      rd_mux = {24'h000000, dbuf_reg};
    end else if (araddr == ADDR_RUN_CTRL) begin
      rd_mux = {24'h000000, run_reg};
    end else if (araddr == ADDR_CAP1_LO) begin
      rd_mux = {24'h000000, cap1_reg[7:0]};
    end else if (araddr == ADDR_CAP1_HI) begin
      rd_mux = {24'h000000, cap1_reg[15:8]};
    end else if (araddr == ADDR_CAP2_LO) begin
      rd_mux = {24'h000000, cap2_reg[7:0]};
    end else if (araddr == ADDR_CAP2_HI) begin
      rd_mux = {24'h000000, cap2_reg[15:8]};
    end else if (araddr == ADDR_MODE) begin
      rd_mux = {24'h000000, mode_reg};
    end else if (araddr == ADDR_FF_CTRL) begin
      rd_mux = {24'h000000, 2'b11, ffc_en_reg[5:2], 2'b11};
    end else if (araddr == ADDR_IRQ_STATUS) begin
      rd_mux = {28'h0000000, irq_status_reg};
    end else if (araddr == ADDR_IRQ_MASK) begin
      rd_mux = {28'h0000000, irq_mask_reg};
    end else begin
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= RESP_OKAY;
    end else if (ar_fire) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_mux;
      rresp_reg  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // Control registers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dbuf_reg <= DBUF_RESET;
      run_reg  <= RUN_RESET;
      mode_reg <= MODE_RESET;
      irq_mask_reg <= 4'h0;
    end else if (wr_byte) begin
      if (aw_addr_reg == ADDR_DBUF_CTRL) begin
        dbuf_reg <= {5'h00, w_data_reg[2:0]};
      end else if (aw_addr_reg == ADDR_RUN_CTRL) begin
        run_reg <= {2'b00, w_data_reg[5:0]};
      end else if (aw_addr_reg == ADDR_MODE) begin
        // The capture bit always reads back as one; a zero only acts once.
        mode_reg <= w_data_reg[7:0] | (8'h01 << MODE_SW_CAPTURE);
      end else if (aw_addr_reg == ADDR_IRQ_MASK) begin
        irq_mask_reg <= w_data_reg[3:0];
      end
    end
  end

  assign sw_capture = wr_byte && (aw_addr_reg == ADDR_MODE)
                      && !w_data_reg[MODE_SW_CAPTURE];
  assign wr_ffc     = wr_byte && (aw_addr_reg == ADDR_FF_CTRL);

  // Compare writes land in the buffer; without double buffering they go straight through.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmp_a_buf_reg <= 16'h0000;
      cmp_b_buf_reg <= 16'h0000;
    end else if (wr_byte) begin
      if (aw_addr_reg == ADDR_CAP1_LO) begin
        cmp_a_buf_reg[7:0] <= w_data_reg[7:0];
      end else if (aw_addr_reg == ADDR_CAP1_HI) begin
        cmp_a_buf_reg[15:8] <= w_data_reg[7:0];
      end else if (aw_addr_reg == ADDR_CAP2_LO) begin
        cmp_b_buf_reg[7:0] <= w_data_reg[7:0];
      end else if (aw_addr_reg == ADDR_CAP2_HI) begin
        cmp_b_buf_reg[15:8] <= w_data_reg[7:0];
      end
    end
  end

  // Reloading at the compare B match keeps a period from being cut short mid-cycle.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmp_a_reg <= 16'h0000;
      cmp_b_reg <= 16'h0000;
    end else if (!dbuf_reg[DBUF_EN_BIT] || match_b) begin
      cmp_a_reg <= cmp_a_buf_reg;
      cmp_b_reg <= cmp_b_buf_reg;
    end
  end

  // Prescaler runs while its run bit is set and clears when stopped.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_reg <= 7'h00;
    end else if (!run_reg[RUN_PRESCALE_BIT]) begin
      pre_reg <= 7'h00;
    end else begin
      pre_reg <= pre_reg + 7'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin1_prev_reg <= 1'b0;
      pin2_prev_reg <= 1'b0;
      first_timer_flipflop_prev_reg <= 1'b0;
    end else begin
      pin1_prev_reg <= first_event_pin;
      pin2_prev_reg <= second_event_pin;
      first_timer_flipflop_prev_reg <= first_timer_flipflop;
    end
  end

  always_comb begin
    tick = 1'b0;
    case (tcc_clk_src_t'(mode_reg[MODE_CLK_LO +: 2]))
      TCC_CLK_PIN:  tick = first_event_pin && !pin1_prev_reg;
      TCC_CLK_FAST: tick = run_reg[RUN_PRESCALE_BIT] && (pre_reg[2:0] == 3'(TAP_FAST - 1));
      TCC_CLK_MID:  tick = run_reg[RUN_PRESCALE_BIT] && (pre_reg[4:0] == 5'(TAP_MID - 1));
      TCC_CLK_SLOW: tick = run_reg[RUN_PRESCALE_BIT] && (pre_reg == 7'(TAP_SLOW - 1));
      default:      tick = 1'b0;
    endcase
  end

  assign run     = run_reg[RUN_COUNTER_BIT];
  assign match_a = run && tick && (count_reg == cmp_a_reg);
  assign match_b = run && tick && (count_reg == cmp_b_reg);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_reg <= 16'h0000;
    end else if (!run) begin
      count_reg <= 16'h0000;
    end else if (match_b && mode_reg[MODE_CLEAR_EN]) begin
      count_reg <= 16'h0000;
    end else if (tick) begin
      count_reg <= count_reg + 16'h0001;
    end
  end

  always_comb begin
    cap1_hw = 1'b0;
    cap2_hw = 1'b0;
    case (tcc_cap_mode_t'(mode_reg[MODE_CAPT_LO +: 2]))
      TCC_CAP_OFF: begin
        cap1_hw = 1'b0;
        cap2_hw = 1'b0;
      end
      TCC_CAP_TWO_PINS: begin
        cap1_hw = first_event_pin && !pin1_prev_reg;
        cap2_hw = second_event_pin && !pin2_prev_reg;
      end
      TCC_CAP_PIN_BOTH: begin
        cap1_hw = first_event_pin && !pin1_prev_reg;
        cap2_hw = !first_event_pin && pin1_prev_reg;
      end
      TCC_CAP_TIMER_FF: begin
        cap1_hw = first_timer_flipflop && !first_timer_flipflop_prev_reg;
        cap2_hw = !first_timer_flipflop && first_timer_flipflop_prev_reg;
      end
      default: begin
        cap1_hw = 1'b0;
        cap2_hw = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cap1_reg <= 16'h0000;
    end else if (cap1_hw || sw_capture) begin
      cap1_reg <= count_reg;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cap2_reg <= 16'h0000;
    end else if (cap2_hw) begin
      cap2_reg <= count_reg;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ffc_en_reg <= FFC_RESET[5:0];
    end else if (wr_ffc) begin
      ffc_en_reg <= w_data_reg[5:0];
    end
  end

  assign ffb_toggle = (mode_reg[MODE_TOG_CAP2_B] && cap2_hw)
                      || (mode_reg[MODE_TOG_MATCH_B] && match_b);
  assign ffa_toggle = (ffc_en_reg[FFC_A_CAP2] && cap2_hw)
                      || (ffc_en_reg[FFC_A_CAP1] && cap1_hw)
                      || (ffc_en_reg[FFC_A_MATCH_B] && match_b)
                      || (ffc_en_reg[FFC_A_MATCH_A] && match_a);

  // A software invert, set or clear command takes priority over a hardware toggle in the same cycle; keep lets the toggle act.
  function automatic logic ff_next(input logic cur, input logic wr,
                                   input logic [1:0] cmd, input logic tog);
    logic res;
    res = tog ? !cur : cur;
    if (wr) begin
      case (tcc_ff_cmd_t'(cmd))
        TCC_FF_INVERT: res = !cur;
        TCC_FF_SET:    res = 1'b1;
        TCC_FF_CLEAR:  res = 1'b0;
        default:       res = tog ? !cur : cur;
      endcase
    end
    return res;
  endfunction : ff_next

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ff_a_reg <= 1'b0;
      ff_b_reg <= 1'b0;
    end else begin
      ff_a_reg <= ff_next(ff_a_reg, wr_ffc, w_data_reg[FFC_A_LO +: 2], ffa_toggle);
      ff_b_reg <= ff_next(ff_b_reg, wr_ffc, w_data_reg[FFC_B_LO +: 2], ffb_toggle);
    end
  end

  assign output_flipflop_a      = ff_a_reg;
  assign second_output_flipflop = ff_b_reg;

  // Sticky status; a new event in the clearing read's cycle survives.
  assign events = {cap2_hw, cap1_hw || sw_capture, match_b, match_a};
  assign status_rd_clear = ar_fire && (araddr == ADDR_IRQ_STATUS);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status_reg <= 4'h0;
    end else begin
      irq_status_reg <= (status_rd_clear ? 4'h0 : irq_status_reg) | events;
    end
  end

  assign irq = |(irq_status_reg & irq_mask_reg);

endmodule : tcc_timer

// *** verif/tcc_timer_sva.sv ***
/*
  Checker for the timer's register reads and output flip-flop commands.
  Assumes the single aclk domain; bound into tcc_timer after the module.
*/
`timescale 1ns/100ps
module tcc_timer_sva
  import tcc_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [31:0] awaddr,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0]  wstrb,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic [31:0] araddr,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic        rvalid,
  input wire logic        output_flipflop_a,
  input wire logic        second_output_flipflop
);
  logic wr_go;
  logic rd_go;
  // Only a write taken whole while no response waits acts at once.
  assign wr_go = awvalid && awready && wvalid && wready && !bvalid && wstrb[0]
                 && awaddr == ADDR_FF_CTRL;
  assign rd_go = arvalid && arready;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_ffc_read;
    rd_go && araddr == ADDR_FF_CTRL |=> rvalid && rdata[7:6] == 2'b11 && rdata[1:0] == 2'b11;
  endproperty
  a_ffc_read: assert property (p_ffc_read) else $error("command fields not read as ones");
  property p_mode_read;
    rd_go && araddr == ADDR_MODE |=> rvalid && rdata[MODE_SW_CAPTURE];
  endproperty
  a_mode_read: assert property (p_mode_read) else $error("capture bit not read as one");
  property p_ffb_set;
    wr_go && wdata[7:6] == TCC_FF_SET |-> ##[1:3] second_output_flipflop;
  endproperty
  a_ffb_set: assert property (p_ffb_set) else $error("second flip-flop not set");
  property p_ffb_clr;
    wr_go && wdata[7:6] == TCC_FF_CLEAR |-> ##[1:3] !second_output_flipflop;
  endproperty
  a_ffb_clr: assert property (p_ffb_clr) else $error("second flip-flop not cleared");
  property p_ffb_inv;
    wr_go && wdata[7:6] == TCC_FF_INVERT && !second_output_flipflop |-> ##[1:3] second_output_flipflop;
  endproperty
  a_ffb_inv: assert property (p_ffb_inv) else $error("second flip-flop not inverted");
  property p_ffb_keep;
    wr_go && wdata[7:6] == TCC_FF_KEEP |=> $stable(second_output_flipflop) [*3];
  endproperty
  a_ffb_keep: assert property (p_ffb_keep) else $error("second flip-flop changed on keep");
  property p_ffa_set;
    wr_go && wdata[1:0] == TCC_FF_SET |-> ##[1:3] output_flipflop_a;
  endproperty
  a_ffa_set: assert property (p_ffa_set) else $error("first flip-flop not set");
  property p_ffa_clr;
    wr_go && wdata[1:0] == TCC_FF_CLEAR |-> ##[1:3] !output_flipflop_a;
  endproperty
  a_ffa_clr: assert property (p_ffa_clr) else $error("first flip-flop not cleared");
endmodule : tcc_timer_sva

bind tcc_timer tcc_timer_sva chk_u (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
  .wstrb, .wvalid, .wready, .bvalid, .araddr, .arvalid, .arready, .rdata, .rvalid,
  .output_flipflop_a, .second_output_flipflop);

// *** verif/tcc_timer_test.sv ***
/*
  Self-checking bench for the timer: AXI4-Lite register tasks and scenarios.
  Assumes the checker is bound in by its own file.
*/
`timescale 1ns/100ps
module tcc_timer_test;
  import tcc_pkg::*;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, v, e;
  logic        first_event_pin, second_event_pin, first_timer_flipflop;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic        output_flipflop_a, second_output_flipflop;
  logic [31:0] awaddr, wdata, araddr, rdata, rd;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rs;
  logic [15:0] c1, c2;
  logic [1:0]  cmd_tab [6] = '{2'b01, 2'b00, 2'b00, 2'b10, 2'b11, 2'b01};
  int          err_total, samples_checked, i, tap;

  tcc_timer dut_u (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .first_event_pin, .second_event_pin, .first_timer_flipflop, .output_flipflop_a,
    .second_output_flipflop, .irq);

  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Whole-byte writes only, entered just after a rising edge.
  task automatic wr(input logic [31:0] a, input logic [7:0] d, output logic [1:0] r);
    logic ta;
    logic tw;
    ta = 1'b0;
    tw = 1'b0;
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= {24'h000000, d};
    wstrb <= 4'h1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge aclk);
      ta = ta | awready;
      tw = tw | wready;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end while (!(ta && tw));
    do @(negedge aclk); while (!bvalid);
    r = bresp;
    // Ready stays high, so back-to-back calls never drop and raise it in one step.
    @(posedge aclk);
  endtask : wr

  task automatic rdr(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge aclk); while (!arready);
    @(posedge aclk);
    arvalid <= 1'b0;
    do @(negedge aclk); while (!rvalid);
    d = rdata;
    r = rresp;
    @(posedge aclk);
  endtask : rdr

  task automatic rchk(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    rdr(a, d, r);
    chk(d, exp);
  endtask : rchk

  task automatic stop_test;
    $display("comparisons %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : stop_test

  initial begin
    repeat (20000) @(posedge aclk);
    err_total++;
    $display("mismatch at %0t: watchdog expired", $time);
    stop_test;
  end

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {first_event_pin, second_event_pin, first_timer_flipflop} = '0;
    {awaddr, wdata, araddr, wstrb} = '0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rchk(ADDR_MODE, {24'h0, MODE_RESET});
    rchk(ADDR_FF_CTRL, {24'h0, FFC_RESET});
    rdr(ADDR_FF_CTRL + 32'h4, rd, rs);
    chk(32'(rs), 32'(RESP_SLVERR));
    wr(ADDR_FF_CTRL + 32'h4, 8'hff, rs);
    chk(32'(rs), 32'(RESP_SLVERR));
    e = 1'b0;
    for (i = 0; i < 6; i++) begin
      wr(ADDR_FF_CTRL, {cmd_tab[i], 4'h0, cmd_tab[i]}, rs);
      case (cmd_tab[i])
        2'b00: e = !e;
        2'b01: e = 1'b1;
        2'b10: e = 1'b0;
        default: e = e;
      endcase
      repeat (2) @(posedge aclk);
      @(negedge aclk);
      chk(32'(second_output_flipflop), 32'(e));
      chk(32'(output_flipflop_a), 32'(e));
      @(posedge aclk);
    end
    rchk(ADDR_FF_CTRL, 32'hc3);
    wr(ADDR_RUN_CTRL, 8'h10, rs);
    for (i = 0; i < 5; i++) begin
      first_event_pin <= 1'b1;
      repeat (2) @(posedge aclk);
      first_event_pin <= 1'b0;
      repeat (2) @(posedge aclk);
    end
    wr(ADDR_MODE, 8'h00, rs);
    rchk(ADDR_CAP1_LO, 32'h5);
    rchk(ADDR_CAP1_HI, 32'h0);
    wr(ADDR_RUN_CTRL, 8'h00, rs);
    wr(ADDR_RUN_CTRL, 8'h10, rs);
    wr(ADDR_MODE, 8'h00, rs);
    rchk(ADDR_CAP1_LO, 32'h0);
    // Spacing the two capture edges by four taps gives a phase-free count.
    wr(ADDR_RUN_CTRL, 8'h30, rs);
    for (i = 1; i < 4; i++) begin
      tap = (i == 1) ? TAP_FAST : (i == 2) ? TAP_MID : TAP_SLOW;
      wr(ADDR_MODE, 8'h20 | 8'(i * 9), rs);
      if (i == 3) first_timer_flipflop <= 1'b1;
      else first_event_pin <= 1'b1;
      repeat (4 * tap) @(posedge aclk);
      if (i == 1) second_event_pin <= 1'b1;
      else if (i == 2) first_event_pin <= 1'b0;
      else first_timer_flipflop <= 1'b0;
      repeat (2) @(posedge aclk);
      rdr(ADDR_CAP1_LO, rd, rs);
      c1[7:0] = rd[7:0];
      rdr(ADDR_CAP1_HI, rd, rs);
      c1[15:8] = rd[7:0];
      rdr(ADDR_CAP2_LO, rd, rs);
      c2[7:0] = rd[7:0];
      rdr(ADDR_CAP2_HI, rd, rs);
      c2[15:8] = rd[7:0];
      chk(32'(16'(c2 - c1)), 32'h4);
      first_event_pin <= 1'b0;
      second_event_pin <= 1'b0;
    end
    wr(ADDR_MODE, 8'h21, rs);
    first_event_pin <= 1'b1;
    repeat (3) @(posedge aclk);
    first_event_pin <= 1'b0;
    rchk(ADDR_CAP1_LO, {24'h0, c1[7:0]});
    wr(ADDR_CAP2_LO, 8'h04, rs);
    wr(ADDR_CAP2_HI, 8'h00, rs);
    wr(ADDR_MODE, 8'h65, rs);
    // The counter is already past compare B here and would need a full wrap to match.
    wr(ADDR_RUN_CTRL, 8'h00, rs);
    wr(ADDR_RUN_CTRL, 8'h30, rs);
    repeat (100) @(posedge aclk);
    @(negedge aclk);
    v = second_output_flipflop;
    repeat (40) @(negedge aclk);
    chk(32'(second_output_flipflop), 32'(!v));
    repeat (40) @(negedge aclk);
    chk(32'(second_output_flipflop), 32'(v));
    @(posedge aclk);
    wr(ADDR_MODE, 8'h25, rs);
    v = second_output_flipflop;
    repeat (80) @(negedge aclk);
    chk(32'(second_output_flipflop), 32'(v));
    @(posedge aclk);
    wr(ADDR_MODE, 8'ha9, rs);
    v = second_output_flipflop;
    second_event_pin <= 1'b1;
    repeat (3) @(posedge aclk);
    second_event_pin <= 1'b0;
    @(negedge aclk);
    chk(32'(second_output_flipflop), 32'(!v));
    @(posedge aclk);
    wr(ADDR_RUN_CTRL, 8'h00, rs);
    wr(ADDR_IRQ_MASK, 8'h00, rs);
    @(negedge aclk);
    chk(32'(irq), 32'h0);
    @(posedge aclk);
    wr(ADDR_IRQ_MASK, 8'h02, rs);
    @(negedge aclk);
    chk(32'(irq), 32'h1);
    @(posedge aclk);
    rdr(ADDR_IRQ_STATUS, rd, rs);
    chk(32'(rd[IRQ_MATCH_B]), 32'h1);
    @(negedge aclk);
    chk(32'(irq), 32'h0);
    stop_test;
  end
endmodule : tcc_timer_test
